// ### shared/hbfr_consts.vh
// Purpose: constants for the half-bridge fault and reset supervisor
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes:   definitions only
`ifndef HBFR_CONSTS_VH
`define HBFR_CONSTS_VH
`define HBFR_ST_POR      2'h0
`define HBFR_ST_RUN      2'h1
`define HBFR_ST_UV       2'h2
`define HBFR_POR_CYC     8'h10
`define HBFR_SYNC_ONES   2'h3
`define HBFR_SYNC_ZERO   2'h0
`define HBFR_CFG_SE      2'h2
`define HBFR_CNT_ZERO    8'h00
`define HBFR_CNT_STEP    8'h01
`define HBFR_PAIRS       2
`define HBFR_PAIR_W      2
`define HBFR_PAIR_AB     0
`define HBFR_PAIR_CD     1
`define HBFR_PAIR_NONE   2'h0
`define HBFR_EN_OFF      4'h0
`define HBFR_PD_OFF      4'h0
`endif

// ### core/hbfr_sync_edge.v
// Purpose: two-flop synchroniser with rising-edge pulse
// Assumes: clock enable freezes state
// Notes:   first flop is read only by the level and rise-pulse flops
`timescale 1ns/1ps
`include "hbfr_consts.vh"
module hbfr_sync_edge (
    input  wire clock_i,
    input  wire rst_i,
    input  wire ce_i,
    input  wire async_i,
    output reg  level_o,
    output reg  rise_o
);
    reg meta_reg;
    always @(posedge clock_i) begin
        if (rst_i) begin
            meta_reg <= 1'b0;
            level_o  <= 1'b0;
            rise_o   <= 1'b0;
        end else if (ce_i) begin
            meta_reg <= async_i;
            level_o  <= meta_reg;
            rise_o   <= meta_reg & ~level_o;
        end
    end
endmodule

// ### core/hbfr_supervisor.v
// Purpose: fault and reset supervisor of a four half-bridge power stage
// Assumes: supply-ok, fault detect and mode inputs are synchronous levels
// Notes:   output enables are high when the half-bridge may switch
`timescale 1ns/1ps
`include "hbfr_consts.vh"
module hbfr_supervisor (
    input  wire       clock_i,
    input  wire       rst_i,
    input  wire       ce_i,
    input  wire       pair_ab_hold_n_i,
    input  wire       pair_cd_hold_n_i,
    input  wire       gate_drive_supply_ok_i,
    input  wire       logic_supply_ok_i,
    input  wire       overload_ab_i,
    input  wire       overload_cd_i,
    input  wire       thermal_error_i,
    input  wire [1:0] out_config_i,
    output reg  [3:0] bridge_enable_o,
    output reg  [3:0] weak_pulldown_o,
    output reg        shutdown_flag_n_o,
    output reg        overload_latch_ab_o,
    output reg        overload_latch_cd_o,
    output reg        thermal_error_latch_o
);
    // Per-pair views: index 0 is the A/B pair, index 1 the C/D pair
    wire [1:0] hold_pin;
    wire [1:0] hold_level;
    wire [1:0] hold_rise;
    wire [1:0] ovl_in;
    wire [1:0] ovl_next;
    wire [3:0] en_next;
    wire [3:0] pd_next;
    reg  [1:0] ovl_reg;
    reg  [1:0] state_reg;
    reg  [1:0] state_next;
    reg  [7:0] por_cnt_reg;
    reg  [7:0] por_cnt_next;
    reg        therm_reg;
    reg        therm_next;
    wire       supply_low_guard;
    wire       any_hold;
    wire       any_rise;
    wire       running;
    wire       run_ok;
    wire       single_ended;
    wire       por_done;
    wire       therm_live;
    wire       flag_fault;

    // Pair may switch only when running, released and fault free
    function pair_on;
        input run;
        input hold_lvl;
        input ovl;
        input therm;
        begin
            pair_on = run & hold_lvl & ~ovl & ~therm;
        end
    endfunction

    // Weak pulldown while held, never in single-ended use
    function pair_pd;
        input hold_lvl;
        input se;
        begin
            pair_pd = ~hold_lvl & ~se;
        end
    endfunction

    assign hold_pin         = {pair_cd_hold_n_i, pair_ab_hold_n_i};
    assign ovl_in           = {overload_cd_i, overload_ab_i};
    assign supply_low_guard = ~gate_drive_supply_ok_i | ~logic_supply_ok_i;
    assign any_hold         = ~(&hold_level);
    assign any_rise         = |hold_rise;
    assign running          = (state_reg == `HBFR_ST_RUN);
    assign run_ok           = running & ~supply_low_guard;
    assign single_ended     = (out_config_i == `HBFR_CFG_SE);
    assign por_done         = (por_cnt_reg == `HBFR_POR_CYC);
    // Live fault terms cut the stage one cycle before the latch shows
    assign therm_live       = therm_reg | thermal_error_i;
    assign flag_fault       = supply_low_guard | ~running | (|ovl_reg) | therm_reg;

    genvar p;
    generate
        for (p = 0; p < `HBFR_PAIRS; p = p + 1) begin : g_pair
            hbfr_sync_edge u_sync (
                .clock_i (clock_i),
                .rst_i   (rst_i),
                .ce_i    (ce_i),
                .async_i (hold_pin[p]),
                .level_o (hold_level[p]),
                .rise_o  (hold_rise[p])
            );

            // Set wins over the clearing edge; held pair ignores overload
            assign ovl_next[p] = (state_reg == `HBFR_ST_POR) ? 1'b0 :
                                 (running & ovl_in[p] & hold_level[p]) ? 1'b1 :
                                 any_rise ? 1'b0 :
                                 ovl_reg[p];

            assign en_next[`HBFR_PAIR_W*p +: `HBFR_PAIR_W] =
                {`HBFR_PAIR_W{pair_on(run_ok, hold_level[p], ovl_reg[p] | ovl_in[p], therm_live)}};

            assign pd_next[`HBFR_PAIR_W*p +: `HBFR_PAIR_W] =
                {`HBFR_PAIR_W{pair_pd(hold_level[p], single_ended)}};
        end
    endgenerate

    // Counter stops at its end value so the compare stays true
    always @* begin
        por_cnt_next = por_cnt_reg;
        if (state_reg == `HBFR_ST_POR && !por_done)
            por_cnt_next = por_cnt_reg + `HBFR_CNT_STEP;
    end

    // Thermal latch only clears with a hold asserted
    always @* begin
        if (running && thermal_error_i)
            therm_next = 1'b1;
        else if (any_hold)
            therm_next = 1'b0;
        else
            therm_next = therm_reg;
    end

    always @* begin
        state_next = state_reg;
        case (state_reg)
            `HBFR_ST_POR: begin
                if (supply_low_guard)
                    state_next = `HBFR_ST_UV;
                else if (por_done)
                    state_next = `HBFR_ST_RUN;
            end
            `HBFR_ST_RUN: begin
                if (supply_low_guard)
                    state_next = `HBFR_ST_UV;
            end
            `HBFR_ST_UV: begin
                if (!supply_low_guard)
                    state_next = `HBFR_ST_RUN;
            end
            default: state_next = `HBFR_ST_POR;
        endcase
    end


    // State, counter and latches; clock enable freezes all of them
    always @(posedge clock_i) begin
        if (rst_i) begin
            state_reg   <= `HBFR_ST_POR;
            por_cnt_reg <= `HBFR_CNT_ZERO;
            ovl_reg     <= `HBFR_PAIR_NONE;
            therm_reg   <= 1'b0;
        end else if (ce_i) begin
            state_reg   <= state_next;
            por_cnt_reg <= por_cnt_next;
            ovl_reg     <= ovl_next;
            therm_reg   <= therm_next;
        end
    end

    // Outputs registered; flag lags the latches by one cycle
    always @(posedge clock_i) begin
        if (rst_i) begin
            bridge_enable_o       <= `HBFR_EN_OFF;
            weak_pulldown_o       <= `HBFR_PD_OFF;
            shutdown_flag_n_o     <= 1'b1;
            overload_latch_ab_o   <= 1'b0;
            overload_latch_cd_o   <= 1'b0;
            thermal_error_latch_o <= 1'b0;
        end else if (ce_i) begin
            bridge_enable_o <= en_next;
            weak_pulldown_o <= pd_next;
            if (any_hold)
                shutdown_flag_n_o <= 1'b1;
            else
                shutdown_flag_n_o <= ~flag_fault;

            overload_latch_ab_o   <= ovl_reg[`HBFR_PAIR_AB];
            overload_latch_cd_o   <= ovl_reg[`HBFR_PAIR_CD];
            thermal_error_latch_o <= therm_reg;
        end
    end

endmodule

// ### bench/hbfr_chk_assertions.sv
// Purpose: port checker for the supervisor
// Assumes: hold pins reach outputs three cycles late
// Notes:   bound by port name
`timescale 1ns/1ps
module hbfr_chk (
    input wire logic       clock_i,
    input wire logic       rst_i,
    input wire logic       ce_i,
    input wire logic       pair_ab_hold_n_i,
    input wire logic       pair_cd_hold_n_i,
    input wire logic       gate_drive_supply_ok_i,
    input wire logic       logic_supply_ok_i,
    input wire logic       overload_ab_i,
    input wire logic       overload_cd_i,
    input wire logic       thermal_error_i,
    input wire logic [1:0] out_config_i,
    input wire logic [3:0] bridge_enable_o,
    input wire logic [3:0] weak_pulldown_o,
    input wire logic       shutdown_flag_n_o,
    input wire logic       overload_latch_ab_o,
    input wire logic       overload_latch_cd_o,
    input wire logic       thermal_error_latch_o
);
    default clocking @(posedge clock_i); endclocking
    // Frozen clock enable stalls the pipeline, so checks pause with it
    default disable iff (rst_i || !ce_i);
    sequence s_up;
        (pair_ab_hold_n_i && pair_cd_hold_n_i) [*3];
    endsequence
    sequence s_ab_low;
        !pair_ab_hold_n_i [*3];
    endsequence
    sequence s_cd_low;
        !pair_cd_hold_n_i [*3];
    endsequence
    sequence s_supply_low;
        !(gate_drive_supply_ok_i && logic_supply_ok_i);
    endsequence
    property p_por;
        $fell(rst_i) |-> !overload_latch_ab_o && !thermal_error_latch_o;
    endproperty
    a_por: assert property (p_por) else $error("latch set after reset");
    property p_uv;
        s_up ##0 s_supply_low |=> bridge_enable_o == 4'h0 && !shutdown_flag_n_o;
    endproperty
    a_uv: assert property (p_uv) else $error("supply drop not handled");
    property p_ab;
        s_ab_low |=> bridge_enable_o[1:0] == 2'h0;
    endproperty
    a_ab: assert property (p_ab) else $error("pair ab switching while held");
    property p_cd;
        s_cd_low |=> bridge_enable_o[3:2] == 2'h0;
    endproperty
    a_cd: assert property (p_cd) else $error("pair cd switching while held");
    property p_pd;
        (gate_drive_supply_ok_i && out_config_i != 2'h2 && !pair_ab_hold_n_i) [*3]
            |=> weak_pulldown_o[1:0] == 2'h3;
    endproperty
    a_pd: assert property (p_pd) else $error("pulldown missing");
    property p_se;
        out_config_i == 2'h2 |=> weak_pulldown_o == 4'h0;
    endproperty
    a_se: assert property (p_se) else $error("pulldown in single ended");
    property p_ovl;
        s_up ##0 overload_ab_i |=> bridge_enable_o[1:0] == 2'h0 ##1 !shutdown_flag_n_o;
    endproperty
    a_ovl: assert property (p_ovl) else $error("overload not handled");
    property p_clr;
        $rose(pair_ab_hold_n_i) ##0 (pair_ab_hold_n_i && !overload_ab_i) [*5] |=> !overload_latch_ab_o;
    endproperty
    a_clr: assert property (p_clr) else $error("overload latch kept");
    property p_clr_cd;
        $rose(pair_cd_hold_n_i) ##0 (pair_cd_hold_n_i && !overload_cd_i) [*5] |=> !overload_latch_cd_o;
    endproperty
    a_clr_cd: assert property (p_clr_cd) else $error("cd overload latch kept");
    property p_te;
        (!pair_ab_hold_n_i && !thermal_error_i) [*5] |=> !thermal_error_latch_o;
    endproperty
    a_te: assert property (p_te) else $error("thermal latch kept");
endmodule
bind hbfr_supervisor hbfr_chk i_hbfr_chk (.*);

// ### bench/hbfr_ctrl_model.sv
// Purpose: controller driving the hold pins
// Assumes: recovers every flag fall by one hold pulse
// Notes:   GAP stands in for the long wait
`timescale 1ns/1ps
module hbfr_ctrl_model #(parameter int GAP = 50) (
    input wire logic clock_i, rst_i, flag_n_i, mute_ab_i, mute_cd_i,
    output logic     hold_ab_o, hold_cd_o
);
    logic flag_q;
    int   cnt;
    always @(posedge clock_i) begin
        flag_q <= flag_n_i;
        if (rst_i) cnt <= 0;
        else if (flag_q && !flag_n_i) cnt <= 1;
        else if (cnt != 0) cnt <= (cnt == GAP + 4) ? 0 : cnt + 1;
    end
    // Release edge never before the gap runs out
    assign hold_ab_o = !mute_ab_i && !(cnt > GAP);
    assign hold_cd_o = !mute_cd_i;
endmodule

// ### bench/hbfr_supervisor_tb.sv
// Purpose: scoreboard bench for the supervisor
// Assumes: ce_i driven by the bench
// Notes:   notes queue holds {enables, pulldowns, flag}
`timescale 1ns/1ps
module hbfr_supervisor_tb;
    localparam int GAP = 50;
    logic clock_i = 0, rst_i = 1, gate_ok = 1, logic_ok = 1, ovl_ab = 0, ovl_cd = 0, therm = 0;
    logic mute_ab = 0, mute_cd = 0, look = 0, m, hold_ab, hold_cd, flag, ol_ab, ol_cd, te, ce = 1;
    logic [1:0] cfg = 0;
    logic [3:0] en, pd;
    logic [8:0] e, notes[$];
    int failures = 0, num_checks = 0, seed = 63407, cycles = 0, k;
    initial forever #5 clock_i = ~clock_i;
    hbfr_ctrl_model #(.GAP(GAP)) i_hbfr_ctrl_model (.clock_i(clock_i), .rst_i(rst_i), .flag_n_i(flag),
        .mute_ab_i(mute_ab), .mute_cd_i(mute_cd), .hold_ab_o(hold_ab), .hold_cd_o(hold_cd));
    hbfr_supervisor i_hbfr_supervisor (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce),
        .pair_ab_hold_n_i(hold_ab), .pair_cd_hold_n_i(hold_cd), .gate_drive_supply_ok_i(gate_ok),
        .logic_supply_ok_i(logic_ok), .overload_ab_i(ovl_ab), .overload_cd_i(ovl_cd),
        .thermal_error_i(therm), .out_config_i(cfg), .bridge_enable_o(en), .weak_pulldown_o(pd),
        .shutdown_flag_n_o(flag), .overload_latch_ab_o(ol_ab), .overload_latch_cd_o(ol_cd),
        .thermal_error_latch_o(te));
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // Outputs are levels, so a settle count replaces a handshake
    task automatic expect_after(input int n, input logic [8:0] exp);
        repeat (n) @(posedge clock_i);
        notes.push_back(exp);
        look <= 1;
        @(posedge clock_i) look <= 0;
    endtask
    always @(posedge clock_i) begin
        cycles++;
        if (cycles > 2000) begin
            failures++;
            close_out();
        end
        if (look) check({en, pd, flag}, notes.pop_front());
    end
    initial begin
        repeat (16) @(posedge clock_i);
        rst_i <= 0;
        expect_after(GAP + 40, {4'hf, 4'h0, 1'b1});
        ce <= 0; ovl_ab <= 1;
        expect_after(3, {4'hf, 4'h0, 1'b1});
        ce <= 1; ovl_ab <= 0;
        for (k = 0; k < 4; k++) begin
            m = $random(seed) % 2 != 0;
            cfg <= k[1:0]; mute_ab <= m; mute_cd <= !m;
            e = {m ? 4'hc : 4'h3, k == 2 ? 4'h0 : (m ? 4'h3 : 4'hc), 1'b1};
            expect_after(6, e);
            ovl_ab <= m; ovl_cd <= !m;
            expect_after(3, e);
            ovl_ab <= 0; ovl_cd <= 0; mute_ab <= 0; mute_cd <= 0;
            expect_after(6, {4'hf, 4'h0, 1'b1});
        end
        cfg <= 0;
        for (k = 0; k < 4; k++) begin
            gate_ok <= (k != 0); ovl_cd <= (k == 1); therm <= (k == 2); ovl_ab <= (k == 3);
            e = {k == 1 ? 4'h3 : (k == 3 ? 4'hc : 4'h0), 4'h0, 1'b0};
            expect_after(3, e);
            gate_ok <= 1; ovl_cd <= 0; therm <= 0; ovl_ab <= 0;
            e[0] = (k == 0);
            if (k == 0) e[8:5] = 4'hf;
            expect_after(3, e);
            expect_after(GAP + 20, {4'hf, 4'h0, 1'b1});
        end
        close_out();
    end
endmodule
